// File: rtm_params.svh
// Register map, field positions, reset values and timing constants for the reader timer.
// Assumes inclusion by the timer module and the testbench only.
`ifndef RTM_PARAMS_SVH
`define RTM_PARAMS_SVH
// Register word indices; the bus byte address is four times the index
`define RTM_OFS_DIV 6'h2A
`define RTM_OFS_CTL 6'h2B
`define RTM_OFS_PRE 6'h2C
`define RTM_OFS_PIN 6'h2D
`define RTM_OFS_FP2E 6'h2E
`define RTM_OFS_FP2F 6'h2F
`define RTM_OFS_STAT 6'h30
`define RTM_OFS_MASK 6'h31
`define RTM_OFS_CNT 6'h32
`define RTM_RST_DIV 8'h07
`define RTM_RST_CTL 8'h06
`define RTM_RST_PRE 8'h0A
`define RTM_RST_PIN 8'h02
`define RTM_BIT_AUTO 5
`define RTM_BIT_STOP_END 3
`define RTM_BIT_STOP_FIRST 2
`define RTM_BIT_START_END 1
`define RTM_BIT_START_FIRST 0
`define RTM_BIT_INV 1
`define RTM_BIT_PP 0
`define RTM_EXP_MAX 5'h15
`define RTM_STAT_EXPIRED 0
`define RTM_STAT_START 1
`define RTM_STAT_STOP 2
`define RTM_CARRIER_KHZ 13560
`endif

// File: rtm_pkg.sv
// Types shared by the reader timer.
// Assumes rtm_params.svh is on the include path.
package rtm_pkg;
  typedef enum logic [1:0] {
    RTM_IDLE = 2'b00,
    RTM_RUN = 2'b01
  } rtm_state_e;
  typedef struct packed {
    logic tx_first_bit;
    logic tx_end;
    logic rx_first_bit;
    logic rx_end;
  } rtm_events_s;
  typedef struct packed {
    logic irq_out;
    logic irq_oe;
  } rtm_pin_s;
endpackage

// File: rtm_timer.sv
// Reader timer with carrier-driven prescaler and request pin output stage.
// Assumes carrier_tick is a one-cycle pulse per 13.56 MHz carrier edge, synchronous to hclk.
// Overview of operation
// (R01) Tick rate is carrier over two^exponent, 0..21
// (R02) Auto reload restarts countdown from preset
// (R03) Without reload, stop at zero, set expired flag
// (R04) Receive end stops timer when enabled
// (R05) First received bit stops timer when enabled
// (R06) Transmit end starts or restarts timer
// (R07) First transmitted bit starts or restarts timer
// (R08) Disabled conditions ignore their events
// (R09) Every start loads the preset value
// (R10) Preset writes wait for next start
// (R11) Zero preset blocks every start
// (R12) Invert bit complements request pin
// (R13) Drive bit selects push-pull or open-drain
// (R14) Software keeps reserved bits at zero
// (R15) Reset values 07h, 06h, 0Ah
// (R16) Pin config resets to 02h
// (R17) Decrement per tick, hold while stopped
`timescale 1ns/10ps
`include "rtm_params.svh"
module rtm_timer
  import rtm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic carrier_tick,
  input wire rtm_events_s events,
  input wire logic irq_bit_in,
  output logic irq_pin_o,
  output logic irq_pin_oe,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave
  logic [7:0] div_r, ctl_r, pre_r, pin_r, stat_r, mask_r, cnt_r;
  logic [7:0] fp2e_r, fp2f_r;
  // Write address kept as a word index
  logic [5:0] waddr_r;
  logic wpend_r;
  logic [7:0] rdmux;
  logic [2:0] ev_set;
  logic [7:0] stat_nxt;
  logic [21:0] presc_r;
  logic tick;
  logic start_ev, stop_ev;
  logic expire;
  rtm_state_e state_r;

  wire addr_ok = hsel && hready && htrans[1];

  // Address phase capture; writes land in the data phase
  // Zero wait states, so the data phase always follows next
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wpend_r <= 1'b0;
      waddr_r <= 6'h00;
    end else begin
      wpend_r <= addr_ok && hwrite;
      waddr_r <= haddr[7:2]; // Byte lanes ignored, word access only
    end
  end

  // Read data registered for the data phase; unmapped reads zero
  always_comb begin
    // Word index selects the register; unmapped and write-only read zero
    case (haddr[7:2])
      `RTM_OFS_DIV: rdmux = div_r;
      `RTM_OFS_CTL: rdmux = ctl_r;
      `RTM_OFS_PRE: rdmux = pre_r;
      `RTM_OFS_PIN: rdmux = pin_r;
      `RTM_OFS_STAT: rdmux = stat_r;
      `RTM_OFS_MASK: rdmux = mask_r;
      `RTM_OFS_CNT: rdmux = cnt_r;
      default: rdmux = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= (addr_ok && !hwrite) ? {24'h00_0000, rdmux} : 32'h0000_0000;
      hreadyout <= 1'b1; // Zero wait states, always OKAY
      hresp <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= `RTM_RST_DIV; // R15
      ctl_r <= `RTM_RST_CTL; // R15
      pre_r <= `RTM_RST_PRE; // R15
      pin_r <= `RTM_RST_PIN; // R16
      mask_r <= 8'h00;
      fp2e_r <= 8'h00;
      fp2f_r <= 8'h00;
    end else if (wpend_r) begin
      case (waddr_r)
        `RTM_OFS_DIV: div_r <= hwdata[7:0];
        `RTM_OFS_CTL: ctl_r <= hwdata[7:0];
        `RTM_OFS_PRE: pre_r <= hwdata[7:0]; // R10
        `RTM_OFS_PIN: pin_r <= hwdata[7:0];
        `RTM_OFS_MASK: mask_r <= {5'h00, hwdata[2:0]};
        `RTM_OFS_FP2E: fp2e_r <= hwdata[7:0];
        `RTM_OFS_FP2F: fp2f_r <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Prescaler: carrier count while running, tick on bit wrap of chosen stage
  // Counter clears while stopped so the first period is whole
  logic [22:0] presc_inc;
  logic [4:0] exp_eff;
  assign exp_eff = (div_r[4:0] > `RTM_EXP_MAX) ? `RTM_EXP_MAX : div_r[4:0]; // R01
  assign presc_inc = {1'b0, presc_r} + 23'h00_0001;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      presc_r <= 22'h00_0000;
    else if (state_r != RTM_RUN || start_ev)
      presc_r <= 22'h00_0000; // Phase aligned to each start
    else if (carrier_tick)
      presc_r <= presc_inc[21:0];
  end

  // Tick when the low exponent bits roll over to zero
  // Exponent above the top setting behaves as the top setting
  always_comb begin
    logic [22:0] m;
    m = (23'h00_0001 << exp_eff) - 23'h00_0001;
    tick = carrier_tick && ((presc_r & m[21:0]) == m[21:0]); // R01
  end

  //////////////////////////////////////////////////////////////////////////////
  // Start and stop qualification
  // A zero preset masks every start source
  assign start_ev = ((events.tx_end && ctl_r[`RTM_BIT_START_END]) // R06 R08
    || (events.tx_first_bit && ctl_r[`RTM_BIT_START_FIRST])) // R07 R08
    && (pre_r != 8'h00); // R11
  assign stop_ev = (events.rx_end && ctl_r[`RTM_BIT_STOP_END]) // R04 R08
    || (events.rx_first_bit && ctl_r[`RTM_BIT_STOP_FIRST]); // R05 R08
  assign expire = state_r == RTM_RUN && tick && cnt_r == 8'h01 && !start_ev && !stop_ev;

  // Counter state; start wins over stop in the same cycle
  // A restart while running simply reloads the preset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= RTM_IDLE;
      cnt_r <= 8'h00;
    end else if (start_ev) begin
      state_r <= RTM_RUN;
      cnt_r <= pre_r; // R09
    end else begin
      case (state_r)
        RTM_RUN: begin
          if (stop_ev)
            state_r <= RTM_IDLE; // R04 R05
          else if (tick) begin
            if (cnt_r == 8'h01) begin
              if (div_r[`RTM_BIT_AUTO])
                cnt_r <= pre_r; // R02
              else begin
                cnt_r <= 8'h00; // R03
                state_r <= RTM_IDLE;
              end
            end else
              cnt_r <= cnt_r - 8'h01; // R17
          end
        end
        RTM_IDLE: cnt_r <= cnt_r; // R17
        default: state_r <= RTM_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sticky status, write one to clear, set wins
  // Bit 0 expired, bit 1 started, bit 2 stopped
  assign ev_set = {stop_ev && state_r == RTM_RUN, start_ev, expire};
  always_comb begin
    stat_nxt = stat_r;
    if (wpend_r && waddr_r == `RTM_OFS_STAT)
      stat_nxt = stat_r & ~{5'h00, hwdata[2:0]};
    stat_nxt = stat_nxt | {5'h00, ev_set}; // R03
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= 8'h00;
      irq <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq <= |(stat_nxt & mask_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Request pin stage; open-drain only drives low
  // Registered so the pin never glitches on config writes
  rtm_pin_s pin_nxt;
  always_comb begin
    pin_nxt.irq_out = irq_bit_in ^ pin_r[`RTM_BIT_INV]; // R12
    pin_nxt.irq_oe = pin_r[`RTM_BIT_PP] | ~pin_nxt.irq_out; // R13
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_pin_o <= 1'b0;
      irq_pin_oe <= 1'b0;
    end else begin
      irq_pin_o <= pin_nxt.irq_out;
      irq_pin_oe <= pin_nxt.irq_oe;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  // All in the hclk domain and quiet during reset
  // Each property except the two bus checks carries the tag of the rule it guards

  // Any start loads the preset
  chk_preset_load: assert property (@(posedge hclk) disable iff (!hresetn)
    start_ev |=> cnt_r == $past(pre_r) && state_r == RTM_RUN) // R09
    else $error("preset not loaded on start");

  // Zero preset keeps an idle timer idle
  chk_zero_block: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == RTM_IDLE && pre_r == 8'h00) |=> state_r == RTM_IDLE) // R11
    else $error("timer started with zero preset");

  // Enabled receive end stops the timer
  chk_stop_end: assert property (@(posedge hclk) disable iff (!hresetn)
    (events.rx_end && ctl_r[3] && !start_ev) |=> state_r == RTM_IDLE) // R04
    else $error("receive end did not stop timer");

  // Enabled first received bit stops the timer
  chk_stop_first: assert property (@(posedge hclk) disable iff (!hresetn)
    (events.rx_first_bit && ctl_r[2] && !start_ev) |=> state_r == RTM_IDLE) // R05
    else $error("first receive bit did not stop timer");

  // One-shot expiry rests at zero with the flag up
  chk_expire_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    (expire && !div_r[5]) |=> stat_r[0] && cnt_r == 8'h00 && state_r == RTM_IDLE) // R03
    else $error("expiry not flagged");

  // Auto reload keeps running from the preset
  chk_auto_reload: assert property (@(posedge hclk) disable iff (!hresetn)
    (expire && div_r[5]) |=> cnt_r == $past(pre_r) && state_r == RTM_RUN) // R02
    else $error("auto reload failed");

  // Stopped counter holds its value
  chk_hold_count: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == RTM_IDLE && !start_ev) |=> $stable(cnt_r)) // R17
    else $error("counter moved while stopped");

  // Pin follows the request bit with optional inversion
  chk_pin_invert: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> irq_pin_o == ($past(irq_bit_in) ^ $past(pin_r[1]))) // R12
    else $error("request pin polarity wrong");

  // Open drain releases a high level
  chk_pin_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    (!pin_r[0] && irq_bit_in != pin_r[1]) |=> !irq_pin_oe) // R13
    else $error("open drain drove high");

  // Push-pull drives both levels
  chk_pin_push: assert property (@(posedge hclk) disable iff (!hresetn)
    pin_r[`RTM_BIT_PP] |=> irq_pin_oe) // R13
    else $error("push-pull pin released");

  // Transmit end starts the timer when enabled
  chk_start_end: assert property (@(posedge hclk) disable iff (!hresetn)
    (events.tx_end && ctl_r[1] && pre_r != 8'h00) |=> state_r == RTM_RUN && cnt_r == $past(pre_r)) // R06
    else $error("transmit end did not start timer");

  // First transmitted bit starts the timer when enabled
  chk_start_first: assert property (@(posedge hclk) disable iff (!hresetn)
    (events.tx_first_bit && ctl_r[0] && pre_r != 8'h00) |=> state_r == RTM_RUN && cnt_r == $past(pre_r)) // R07
    else $error("first transmit bit did not start timer");

  // Disabled start sources leave an idle timer idle
  chk_ignore_start: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == RTM_IDLE && !(events.tx_end && ctl_r[1]) && !(events.tx_first_bit && ctl_r[0]))
    |=> state_r == RTM_IDLE) // R08
    else $error("disabled start condition acted");

  // No tick and no start means no count change
  chk_preset_defer: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == RTM_RUN && !start_ev && !tick) |=> cnt_r == $past(cnt_r)) // R10
    else $error("count changed without tick");

  // Each tick above one removes exactly one
  chk_decrement: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == RTM_RUN && tick && cnt_r != 8'h01 && !start_ev && !stop_ev)
    |=> cnt_r == $past(cnt_r) - 8'h01) // R17
    else $error("count did not step by one");

  // Ticks only come with a carrier edge
  chk_tick_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    !carrier_tick |-> !tick) // R01
    else $error("tick without carrier edge");

  // Effective exponent stays within range
  chk_exp_clamp: assert property (@(posedge hclk) disable iff (!hresetn)
    exp_eff <= `RTM_EXP_MAX) // R01
    else $error("divider exponent out of range");

  // Expired flag is sticky until written one
  chk_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    (stat_r[0] && !(wpend_r && waddr_r == `RTM_OFS_STAT && hwdata[0])) |=> stat_r[0]) // R03
    else $error("expired flag lost");

  // Start is recorded in status
  chk_start_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    start_ev |=> stat_r[`RTM_STAT_START]) // R09
    else $error("start not recorded");

  // Stop of a running timer is recorded in status
  chk_stop_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    (stop_ev && state_r == RTM_RUN) |=> stat_r[`RTM_STAT_STOP]) // R04
    else $error("stop not recorded");

  // Bus never stalls
  chk_ready_high: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout)
    else $error("slave inserted a wait state");

  // Bus always answers okay with clean upper bytes
  chk_okay_resp: assert property (@(posedge hclk) disable iff (!hresetn)
    !hresp && hrdata[31:8] == 24'h00_0000)
    else $error("bad response or read data");

endmodule // rtm_timer

// File: rtm_host.sv
// Host-side model of the request pin as the microprocessor sees it.
// Assumes a pull-up on the board, so a released pin reads high.
`timescale 1ns/10ps
module rtm_host (
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic level
);
  // Released pin floats up through the pull-up
  assign level = pin_oe ? pin_o : 1'b1;
endmodule // rtm_host

// File: rtm_timer_tb.sv
// Self-checking bench for rtm_timer: AHB-Lite register tasks and timer scenarios.
// Assumes rtm_pkg and rtm_params.svh compiled ahead; hready is the slave's hreadyout.
`timescale 1ns/10ps
`include "rtm_params.svh"
module rtm_timer_tb;
  import rtm_pkg::*;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, carrier_tick = 0, irq_bit_in = 0;
  logic irq_pin_o, irq_pin_oe, irq, lvl;
  rtm_events_s events = 4'h0;
  logic [31:0] q;
  int fails = 0;
  int n_tests = 0;
  rtm_timer u_rtm_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .carrier_tick(carrier_tick), .events(events),
    .irq_bit_in(irq_bit_in), .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe), .irq(irq));
  rtm_host u_rtm_host (.pin_o(irq_pin_o), .pin_oe(irq_pin_oe), .level(lvl));
  // 125 MHz clock
  always #4 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////////
  // Compare and verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One single transfer; waits on hready rather than assuming its timing
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {a[5:0], 2'b00}; // Word index to byte address
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q & m, exp);
  endtask
  // One-cycle event pulse, then two settle cycles
  task ev(input logic [3:0] e);
    events <= e;
    @(posedge hclk);
    events <= 4'h0;
    repeat (2) @(posedge hclk);
  endtask
  task ticks(input int n);
    carrier_tick <= 1'b1;
    repeat (n) @(posedge hclk);
    carrier_tick <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: whole sequence needs well under 2000 cycles
  initial begin
    #100000;
    fails++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`RTM_OFS_DIV, 32'hFFFFFFFF, 32'h07);
    rd(`RTM_OFS_CTL, 32'hFFFFFFFF, 32'h06);
    rd(`RTM_OFS_PRE, 32'hFFFFFFFF, 32'h0A);
    rd(`RTM_OFS_PIN, 32'hFFFFFFFF, 32'h02);
    rd(`RTM_OFS_FP2E, 32'hFFFFFFFF, 32'h00);
    wr(8'h3F, 32'h55);
    rd(8'h3F, 32'hFFFFFFFF, 32'h00);
    // Pin stage over every invert and drive setting
    for (int c = 0; c < 4; c++) begin
      for (int b = 0; b < 2; b++) begin
        wr(`RTM_OFS_PIN, c);
        irq_bit_in <= b[0];
        repeat (3) @(posedge hclk);
        chk({lvl, irq_pin_oe}, {b[0] ^ c[1], c[0] | ~(b[0] ^ c[1])});
      end
    end
    // One-shot expiry raises the masked interrupt
    wr(`RTM_OFS_DIV, 32'h00);
    wr(`RTM_OFS_PRE, 32'h03);
    wr(`RTM_OFS_CTL, 32'h02);
    wr(`RTM_OFS_MASK, 32'h01);
    ev(4'h4);
    ticks(10);
    rd(`RTM_OFS_STAT, 32'h01, 32'h01);
    rd(`RTM_OFS_CNT, 32'hFF, 32'h00);
    chk(irq, 1'b1);
    wr(`RTM_OFS_STAT, 32'h01);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    // Load, hold while no ticks, preset write deferred
    wr(`RTM_OFS_PRE, 32'h05);
    ev(4'h4);
    rd(`RTM_OFS_CNT, 32'hFF, 32'h05);
    wr(`RTM_OFS_PRE, 32'h09);
    rd(`RTM_OFS_CNT, 32'hFF, 32'h05);
    ev(4'h8);
    rd(`RTM_OFS_CNT, 32'hFF, 32'h05);
    wr(`RTM_OFS_CTL, 32'h01);
    ev(4'h2);
    ev(4'h8);
    rd(`RTM_OFS_CNT, 32'hFF, 32'h09);
    // First received bit halts the count
    wr(`RTM_OFS_CTL, 32'h05);
    ev(4'h2);
    ticks(20);
    rd(`RTM_OFS_CNT, 32'hFF, 32'h09);
    // End of reception halts the count
    wr(`RTM_OFS_CTL, 32'h09);
    ev(4'h8);
    ev(4'h1);
    ticks(20);
    rd(`RTM_OFS_CNT, 32'hFF, 32'h09);
    // Zero preset refuses to start
    wr(`RTM_OFS_PRE, 32'h00);
    ev(4'h8);
    ticks(20);
    rd(`RTM_OFS_CNT, 32'hFF, 32'h09);
    // Exponent 2: eight carrier ticks make two decrements
    wr(`RTM_OFS_DIV, 32'h02);
    wr(`RTM_OFS_PRE, 32'h05);
    ev(4'h8);
    ticks(8);
    rd(`RTM_OFS_CNT, 32'hFF, 32'h03);
    // Auto reload keeps the counter from resting at zero
    wr(`RTM_OFS_DIV, 32'h20);
    wr(`RTM_OFS_PRE, 32'h02);
    ev(4'h8);
    ticks(21);
    rd(`RTM_OFS_CNT, 32'hFF, 32'h01);
    chk(q[7:0] != 8'h00, 1'b1);
    end_of_test();
  end
endmodule // rtm_timer_tb
